/* File: verilog/dcpll_cfg_top.sv */
// Summary of operation
// - Bit 31 high holds post and feedback dividers in reset.
// - Bit 30 low enables half clock for odd post divisors.
// - Five-bit post divisor field decodes through a non-binary table; 11111 reserved.
// - Post divisor of one keeps the synthesiser enabled regardless.
// - Bit 8 high bypasses the synthesiser and resets its control voltage.
// - Bit 23 adds one to twice the feedback code value.
// - Eleven-bit feedback code carries the table-encoded count, 1 to 400.
// - Three-bit input divisor field selects value plus two.
// - Bit 10 low: dot clock equals reference times feedback over post times input divisor; bit 10 high: television clock input.
`default_nettype none
module dcpll_cfg_top #(
   parameter int unsigned SETTLE_CYCLES = dcpll_pkg::SETTLE_CYC
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Memory-mapped register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [3:0]  reg_be,
   input  wire logic [31:0] reg_wdata,
   output logic      [31:0] reg_rdata,
   output logic             reg_rvalid,
   // Clock sources and dot clock output
   input  wire logic        synth_clock_in,
   input  wire logic        television_clock_input,
   output logic             dot_clock_out,
   // Synthesiser controls
   output logic             post_divisor_reset,
   output logic             feedback_divisor_reset,
   output logic             pll_bypass,
   output logic             vco_control_reset,
   output logic             pll_enable,
   output logic             half_clock_active,
   output logic [4:0]       post_divisor,
   output logic             post_divisor_reserved,
   output logic [3:0]       input_divisor,
   output logic [10:0]      feedback_divisor_code,
   output logic             feedback_divisor_odd,
   // Status
   output logic             settle_elapsed
);

   // ----------------------------------------------------------------
   // Configuration register
   // ----------------------------------------------------------------
   logic [31:0] cfg_ff;
   logic [31:0] nxt_cfg;
   logic [31:0] lane_mask;
   logic        hit;

   assign hit       = (reg_addr == dcpll_pkg::CFG_OFFSET);
   assign lane_mask = {{8{reg_be[3]}}, {8{reg_be[2]}}, {8{reg_be[1]}}, {8{reg_be[0]}}}
                    & dcpll_pkg::CFG_WR_MASK;
   assign nxt_cfg   = (cfg_ff & ~lane_mask) | (reg_wdata & lane_mask);

   // Enabled byte lanes update on one edge, so all controls move together
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_ff <= dcpll_pkg::CFG_RESET;
      end else if (reg_wr && hit) begin
         cfg_ff <= nxt_cfg;
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   logic [31:0] rd_view;

   // Reserved bits are masked out, bit 5 shows its fixed value
   always_comb begin
      rd_view = cfg_ff & dcpll_pkg::CFG_WR_MASK;
      rd_view[dcpll_pkg::RO_BIT] = dcpll_pkg::CFG_RO_BIT5;
   end

   // Read answer one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata  <= 32'h00000000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= hit ? rd_view : 32'h00000000;
         end
      end
   end

   // ----------------------------------------------------------------
   // Field decode
   // ----------------------------------------------------------------
   dcpll_dec_if dif ();

   assign dif.pd_code      = cfg_ff[dcpll_pkg::PD_MSB:dcpll_pkg::PD_LSB];
   assign dif.id_code      = cfg_ff[dcpll_pkg::ID_MSB:dcpll_pkg::ID_LSB];
   assign dif.clk_on_bit   = cfg_ff[dcpll_pkg::CLK_ON_BIT];
   assign dif.half_off_bit = cfg_ff[dcpll_pkg::HALF_OFF_BIT];

   dcpll_decode u_decode (
      .d (dif)
   );

   // ----------------------------------------------------------------
   // Synthesiser controls
   // ----------------------------------------------------------------
   // Divider resets follow bit 31
   assign post_divisor_reset     = cfg_ff[dcpll_pkg::FB_RESET_BIT];
   assign feedback_divisor_reset = cfg_ff[dcpll_pkg::FB_RESET_BIT];
   // Bypass routes input to output and discharges the VCO
   assign pll_bypass             = cfg_ff[dcpll_pkg::BYPASS_BIT];
   assign vco_control_reset      = cfg_ff[dcpll_pkg::BYPASS_BIT];
   assign pll_enable             = dif.pll_enable;
   assign half_clock_active      = dif.half_clock_active;
   // Divisor values to the analog loop, forming the output ratio
   assign post_divisor           = dif.pd_value;
   assign post_divisor_reserved  = dif.pd_reserved;
   assign input_divisor          = dif.id_value;
   assign feedback_divisor_code  = cfg_ff[dcpll_pkg::FB_CODE_MSB:dcpll_pkg::FB_CODE_LSB];
   assign feedback_divisor_odd   = cfg_ff[dcpll_pkg::FB_ODD_BIT];

   // Dot clock source select
   assign dot_clock_out = cfg_ff[dcpll_pkg::DOT_SEL_BIT] ? television_clock_input
                                                          : synth_clock_in;

   // ----------------------------------------------------------------
   // Settling timer
   // ----------------------------------------------------------------
   localparam logic [dcpll_pkg::SETTLE_W-1:0] SETTLE_LAST =
      dcpll_pkg::SETTLE_W'(SETTLE_CYCLES - 1);

   logic [dcpll_pkg::SETTLE_W-1:0] settle_cnt_ff;
   logic                           offline;

   assign offline = cfg_ff[dcpll_pkg::FB_RESET_BIT] & cfg_ff[dcpll_pkg::BYPASS_BIT];

   // Counts cycles spent off line so software can see the wait is over
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         settle_cnt_ff  <= '0;
         settle_elapsed <= 1'b0;
      end else if (!offline) begin
         settle_cnt_ff  <= '0;
         settle_elapsed <= 1'b0;
      end else if (settle_cnt_ff == SETTLE_LAST) begin
         settle_elapsed <= 1'b1;
      end else begin
         settle_cnt_ff  <= settle_cnt_ff + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_RESET_HOLD : assert property (@(posedge clk) disable iff (sys_rst)
      (reg_wr && hit && reg_be[3]) |=>
         (post_divisor_reset == $past(reg_wdata[31]))
         && (feedback_divisor_reset == $past(reg_wdata[31])))
      else $error("divider reset does not follow bit 31");

   AST_HALF_CLOCK : assert property (@(posedge clk) disable iff (sys_rst)
      half_clock_active |-> (!cfg_ff[30] && post_divisor[0]))
      else $error("half clock active without odd divisor and enable");

   AST_PD_TABLE : assert property (@(posedge clk) disable iff (sys_rst)
      (cfg_ff[28:24] == 5'h07) |-> (post_divisor == 5'h02))
      else $error("post divisor code 00111 not decoded as two");

   AST_PD_RSVD : assert property (@(posedge clk) disable iff (sys_rst)
      post_divisor_reserved == (cfg_ff[28:24] == 5'h1F))
      else $error("reserved post divisor flag wrong");

   AST_ENABLE : assert property (@(posedge clk) disable iff (sys_rst)
      (reg_wr && hit && reg_be[1] && reg_wdata[11]) |=> pll_enable)
      else $error("enable bit write did not enable synthesiser");

   AST_DIV_ONE : assert property (@(posedge clk) disable iff (sys_rst)
      (cfg_ff[28:24] == 5'h0F) |-> (pll_enable && post_divisor == 5'h01))
      else $error("divide by one does not force enable");

   AST_BYPASS : assert property (@(posedge clk) disable iff (sys_rst)
      (reg_wr && hit && reg_be[1]) |=>
         (pll_bypass == $past(reg_wdata[8])) && (vco_control_reset == pll_bypass))
      else $error("bypass controls do not follow bit 8");

   AST_FB_FIELDS : assert property (@(posedge clk) disable iff (sys_rst)
      (reg_wr && hit && (reg_be[2:1] == 2'h3)) |=>
         (feedback_divisor_odd == $past(reg_wdata[23]))
         && (feedback_divisor_code == $past(reg_wdata[22:12])))
      else $error("feedback fields not updated from write");

   AST_ID_VALUE : assert property (@(posedge clk) disable iff (sys_rst)
      input_divisor == ({1'b0, cfg_ff[2:0]} + 4'h2))
      else $error("input divisor not code plus two");

   AST_READ_BACK : assert property (@(posedge clk) disable iff (sys_rst)
      (reg_rd && hit) |=> (reg_rvalid && reg_rdata[29] == 1'b0 && reg_rdata[9] == 1'b0
                           && reg_rdata[7:3] == 5'h00))
      else $error("reserved bits read back non-zero");

   AST_SETTLE : assert property (@(posedge clk) disable iff (sys_rst)
      $rose(settle_elapsed) |-> (offline && settle_cnt_ff == SETTLE_LAST))
      else $error("settle flag rose early");

   AST_ENABLE_OFF : assert property (@(posedge clk) disable iff (sys_rst)
      (reg_wr && hit && reg_be[3] && reg_be[1] && !reg_wdata[11]
       && reg_wdata[28:24] != 5'h0F) |=> !pll_enable)
      else $error("enable bit clear did not disable synthesiser");

   AST_DOT_SEL : assert property (@(posedge clk) disable iff (sys_rst)
      dot_clock_out == (cfg_ff[dcpll_pkg::DOT_SEL_BIT] ? television_clock_input
                                                       : synth_clock_in))
      else $error("dot clock source does not follow bit 10");

endmodule : dcpll_cfg_top
`default_nettype wire

/* File: verilog/dcpll_pkg.sv */
`default_nettype none
package dcpll_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0]  CFG_OFFSET   = 8'h24;       // Dot clock configuration word
   localparam logic [31:0] CFG_RESET    = 32'h00000000;
   localparam logic [31:0] CFG_WR_MASK  = 32'hDFFFFD07; // Bits software may change
   localparam logic        CFG_RO_BIT5  = 1'b0;        // Fixed read-only value

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int unsigned FB_RESET_BIT = 31;
   localparam int unsigned HALF_OFF_BIT = 30;
   localparam int unsigned PD_MSB       = 28;
   localparam int unsigned PD_LSB       = 24;
   localparam int unsigned FB_ODD_BIT   = 23;
   localparam int unsigned FB_CODE_MSB  = 22;
   localparam int unsigned FB_CODE_LSB  = 12;
   localparam int unsigned CLK_ON_BIT   = 11;
   localparam int unsigned DOT_SEL_BIT  = 10;
   localparam int unsigned BYPASS_BIT   = 8;
   localparam int unsigned RO_BIT       = 5;
   localparam int unsigned ID_MSB       = 2;
   localparam int unsigned ID_LSB       = 0;

   // ----------------------------------------------------------------
   // Divisor encodings
   // ----------------------------------------------------------------
   localparam logic [4:0] PD_CODE_ONE  = 5'h0F;         // Divide by one
   localparam logic [4:0] PD_CODE_RSVD = 5'h1F;         // Reserved code
   localparam logic [3:0] ID_OFFSET    = 4'h2;          // Input divisor = code + 2
   // Post divisor lookup, entry 31 first
   localparam logic [31:0][4:0] PD_LUT = {
      5'h00, 5'h1F, 5'h1D, 5'h17, 5'h1B, 5'h0F, 5'h15, 5'h0B,
      5'h03, 5'h19, 5'h11, 5'h0D, 5'h05, 5'h13, 5'h07, 5'h09,
      5'h01, 5'h1E, 5'h1C, 5'h16, 5'h1A, 5'h0E, 5'h14, 5'h0A,
      5'h02, 5'h18, 5'h10, 5'h0C, 5'h04, 5'h12, 5'h06, 5'h08};

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ      = 200;
   localparam int unsigned SETTLE_US    = 500;
   localparam int unsigned SETTLE_CYC   = SETTLE_US * CLK_MHZ;
   localparam int unsigned SETTLE_W     = 17;

endpackage : dcpll_pkg
`default_nettype wire

/* File: verilog/dcpll_dec_if.sv */
`default_nettype none
interface dcpll_dec_if;
   // Raw fields from the configuration word
   logic [4:0] pd_code;
   logic [2:0] id_code;
   logic       clk_on_bit;
   logic       half_off_bit;
   // Decoded values
   logic [4:0] pd_value;
   logic       pd_reserved;
   logic       pd_odd;
   logic [3:0] id_value;
   logic       pll_enable;
   logic       half_clock_active;

   modport regs (output pd_code, id_code, clk_on_bit, half_off_bit,
                 input  pd_value, pd_reserved, pd_odd, id_value, pll_enable,
                        half_clock_active);
   modport dec  (input  pd_code, id_code, clk_on_bit, half_off_bit,
                 output pd_value, pd_reserved, pd_odd, id_value, pll_enable,
                        half_clock_active);
endinterface : dcpll_dec_if
`default_nettype wire

/* File: verilog/dcpll_decode.sv */
`default_nettype none
module dcpll_decode (
   dcpll_dec_if.dec d
);

   // ----------------------------------------------------------------
   // Divisor decode
   // ----------------------------------------------------------------
   // Post divisor through the non-binary table
   assign d.pd_value    = dcpll_pkg::PD_LUT[d.pd_code];
   assign d.pd_reserved = (d.pd_code == dcpll_pkg::PD_CODE_RSVD);
   assign d.pd_odd      = d.pd_value[0];
   // Input divisor is the code plus two
   assign d.id_value    = {1'b0, d.id_code} + dcpll_pkg::ID_OFFSET;
   // Divide-by-one forces the synthesiser on
   assign d.pll_enable  = d.clk_on_bit
                        | (d.pd_code == dcpll_pkg::PD_CODE_ONE);
   // Half clock only matters for odd post divisors; low bit enables it
   assign d.half_clock_active = ~d.half_off_bit & d.pd_odd & ~d.pd_reserved;

endmodule : dcpll_decode
`default_nettype wire

/* File: verification/testbench.sv */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic        clk;
   logic        sys_rst;
   logic [7:0]  reg_addr;
   logic        reg_wr;
   logic        reg_rd;
   logic [3:0]  reg_be;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic        reg_rvalid;
   logic        synth_clock_in;
   logic        television_clock_input;
   logic        dot_clock_out;
   logic        post_divisor_reset;
   logic        feedback_divisor_reset;
   logic        pll_bypass;
   logic        vco_control_reset;
   logic        pll_enable;
   logic        half_clock_active;
   logic [4:0]  post_divisor;
   logic        post_divisor_reserved;
   logic [3:0]  input_divisor;
   logic [10:0] feedback_divisor_code;
   logic        feedback_divisor_odd;
   logic        settle_elapsed;
   logic [31:0] cfg;
   logic [31:0] seed;
   logic [31:0] r;
   logic [31:0] b;
   int          error_cnt;
   int          samples_checked;
   // Post divisor by field code, reserved code gives 0
   logic [4:0]  pd_tab [32] = '{5'h08, 5'h06, 5'h12, 5'h04, 5'h0C, 5'h10, 5'h18, 5'h02,
                                5'h0A, 5'h14, 5'h0E, 5'h1A, 5'h16, 5'h1C, 5'h1E, 5'h01,
                                5'h09, 5'h07, 5'h13, 5'h05, 5'h0D, 5'h11, 5'h19, 5'h03,
                                5'h0B, 5'h15, 5'h0F, 5'h1B, 5'h17, 5'h1D, 5'h1F, 5'h00};

   // Short settle count so the off line wait fits the run
   localparam int unsigned SETTLE_TB = 8;

   // Device under test with a short settle count
   dcpll_cfg_top #(.SETTLE_CYCLES(SETTLE_TB)) dcpll_cfg_top_inst (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .synth_clock_in(synth_clock_in),
      .television_clock_input(television_clock_input), .dot_clock_out(dot_clock_out),
      .post_divisor_reset(post_divisor_reset), .feedback_divisor_reset(feedback_divisor_reset),
      .pll_bypass(pll_bypass), .vco_control_reset(vco_control_reset),
      .pll_enable(pll_enable), .half_clock_active(half_clock_active),
      .post_divisor(post_divisor), .post_divisor_reserved(post_divisor_reserved),
      .input_divisor(input_divisor), .feedback_divisor_code(feedback_divisor_code),
      .feedback_divisor_odd(feedback_divisor_odd), .settle_elapsed(settle_elapsed));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // 200 MHz clock
   always #2.5 clk = ~clk;

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic conclude();
      if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Every control output against the modelled word
   task automatic check_outs();
      chk(feedback_divisor_reset, cfg[31]);
      chk(post_divisor_reset, cfg[31]);
      chk(pll_bypass, cfg[8]);
      chk(vco_control_reset, cfg[8]);
      chk(post_divisor, pd_tab[cfg[28:24]]);
      chk(post_divisor_reserved, cfg[28:24] == 5'h1F);
      chk(pll_enable, cfg[11] | (cfg[28:24] == 5'h0F));
      chk(half_clock_active, !cfg[30] & pd_tab[cfg[28:24]][0]);
      chk(input_divisor, {1'b0, cfg[2:0]} + 4'h2);
      chk(feedback_divisor_code, cfg[22:12]);
      chk(feedback_divisor_odd, cfg[23]);
      chk(dot_clock_out, cfg[10] ? television_clock_input : synth_clock_in);
   endtask : check_outs

   // One write strobe, model update, then output check
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge clk);
      #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      reg_be = be;
      {synth_clock_in, television_clock_input} = d[1:0] ^ seed[9:8];
      @(posedge clk);
      #1;
      reg_wr = 1'b0;
      if (a == dcpll_pkg::CFG_OFFSET) begin
         for (int i = 0; i < 4; i++) if (be[i]) cfg[8*i +: 8] = d[8*i +: 8];
         cfg = cfg & dcpll_pkg::CFG_WR_MASK;
      end
      check_outs();
   endtask : wr

   // One read strobe, answer exactly one cycle later
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      #1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clk);
      #1;
      reg_rd = 1'b0;
      chk(reg_rvalid, 32'h00000001);
      chk(reg_rdata, (a == dcpll_pkg::CFG_OFFSET) ? cfg : 32'h00000000);
      @(posedge clk);
      #1;
      chk(reg_rvalid, 32'h00000000);
   endtask : rd

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {clk, reg_wr, reg_rd, synth_clock_in, television_clock_input} = '0;
      {reg_addr, reg_be, reg_wdata, cfg, error_cnt, samples_checked} = '0;
      seed = 32'h3E0A996B;
      sys_rst = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      check_outs();
      rd(8'h24);
      // Every post divisor code
      for (int i = 0; i < 32; i++) begin
         r = xs();
         r[28:24] = i[4:0];
         wr(8'h24, r, 4'hF);
      end
      // Random words with random byte lanes
      repeat (200) begin
         r = xs();
         b = xs();
         wr(8'h24, r, b[3:0]);
         if (b[4]) rd(8'h24);
      end
      // Reset in mid-run puts every control back to its reset value
      @(posedge clk);
      #1;
      sys_rst = 1'b1;
      cfg = dcpll_pkg::CFG_RESET;
      repeat (3) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      check_outs();
      chk(settle_elapsed, 32'h00000000);
      rd(8'h24);
      // Unmapped address is ignored and reads zero
      wr(8'h28, xs(), 4'hF);
      rd(8'h28);
      // Read in the same cycle as a write returns the old word
      @(posedge clk);
      #1;
      {reg_wr, reg_rd, reg_addr, reg_be, reg_wdata} = {2'b11, 8'h24, 4'hF, xs()};
      @(posedge clk);
      #1;
      {reg_wr, reg_rd} = 2'b00;
      chk(reg_rvalid, 32'h00000001);
      chk(reg_rdata, cfg);
      cfg = reg_wdata & dcpll_pkg::CFG_WR_MASK;
      check_outs();
      // Frequency change: new divisors, off line, settle, then release
      wr(8'h24, xs() & 32'h7FFFFEFF, 4'hF);
      wr(8'h24, cfg | 32'h80000100, 4'hF);
      repeat (SETTLE_TB - 1) @(posedge clk);
      #1;
      chk(settle_elapsed, 32'h00000000);
      @(posedge clk);
      #1;
      chk(settle_elapsed, 32'h00000001);
      // Divisors rewritten while still off line
      wr(8'h24, xs() | 32'h80000100, 4'hF);
      wr(8'h24, cfg & 32'h7FFFFFFF, 4'hF);
      @(posedge clk);
      #1;
      chk(settle_elapsed, 32'h00000000);
      wr(8'h24, cfg & 32'hFFFFFEFF, 4'hF);
      conclude();
   end

   // Watchdog against a hang
   initial begin
      #50000;
      error_cnt++;
      conclude();
   end

endmodule : testbench
`default_nettype wire
